// ==== rtl/temp_alarm_core.sv ====
// temperature sensor alarm logic with three-wire serial slave
`timescale 1ns/10ps
module temp_alarm_core #(
	parameter int unsigned CONV_CYCLES_P = temp_alarm_pkg::CONV_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// serial pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sio_in,
	output logic sio_out,
	output logic sio_oe,
	// alarm pins, open drain
	output logic alert_out,
	output logic alert_oe,
	output logic overtemp_output_out,
	output logic overtemp_output_oe,
	// analog front end result
	input wire logic [15:0] adc_temp,
	// status
	output logic conv_strobe,
	output logic shutdown
);
	import temp_alarm_pkg::*;

	core_state_t q, d;

	// signed compare of all 16 bits of both operands
	function automatic logic gt(input logic [15:0] a, input logic [15:0] b);
		return $signed(a) > $signed(b);
	endfunction : gt

	function automatic logic [2:0] qstep(input logic [2:0] c, input logic hit,
		input logic en);
		logic [2:0] n;
		n = 3'h0;
		if (hit) begin
			n = (c < QUEUE_DEPTH) ? 3'(c + 3'h1) : c;
		end
		if (!en && hit) begin
			n = QUEUE_DEPTH;
		end
		return n;
	endfunction : qstep

	function automatic logic valid_cmd(input logic [7:0] c);
		case (c)
			CMD_RD_TEMP, CMD_RD_CFG, CMD_RD_HYST, CMD_RD_CRIT, CMD_RD_LOW, CMD_RD_HIGH,
			CMD_WR_CFG, CMD_WR_HYST, CMD_WR_CRIT, CMD_WR_LOW, CMD_WR_HIGH: begin
				return 1'b1;
			end
			default: begin
				return 1'b0;
			end
		endcase
	endfunction : valid_cmd

	logic sclk_rise, sclk_fall, cs_hi, sin, conv_done, read_temp, access;
	logic [15:0] t, hi_hy, lo_hy, cr_hy, rd_word;
	logic [7:0] cmd_next;

	always_comb begin
		d = q;
		// ----------------------------------------
		// synchronisers
		// ----------------------------------------
		d.cs_s = {q.cs_s[0], cs_n};
		d.sclk_s = {q.sclk_s[0], sclk};
		d.sio_s = {q.sio_s[0], sio_in};
		d.sclk_prev = q.sclk_s[1];
		cs_hi = q.cs_s[1];
		sin = q.sio_s[1];
		sclk_rise = q.sclk_s[1] && !q.sclk_prev;
		sclk_fall = !q.sclk_s[1] && q.sclk_prev;
		read_temp = 1'b0;
		access = 1'b0;
		cmd_next = {q.cmd[6:0], sin};
		case (q.cmd)
			CMD_RD_TEMP: rd_word = q.temp;
			CMD_RD_CFG: rd_word = q.cfg;
			CMD_RD_HYST: rd_word = q.hyst;
			CMD_RD_CRIT: rd_word = q.crit;
			CMD_RD_LOW: rd_word = q.low;
			CMD_RD_HIGH: rd_word = q.high;
			default: rd_word = 16'h0000;
		endcase
		// ----------------------------------------
		// serial slave
		// ----------------------------------------
		if (cs_hi) begin
			// complete frame only when exactly 24 clocks were seen
			if (q.st == SER_DATA && q.bits == FRAME_BITS) begin
				access = 1'b1;
				if (!q.cmd[CMD_DIR_BIT]) begin
					case (q.cmd)
						CMD_WR_CFG: d.cfg = q.shift & CFG_WR_MASK;
						CMD_WR_HYST: d.hyst = q.shift & LIMIT_MASK;
						CMD_WR_CRIT: d.crit = q.shift & LIMIT_MASK;
						CMD_WR_LOW: d.low = q.shift & LIMIT_MASK;
						CMD_WR_HIGH: d.high = q.shift & LIMIT_MASK;
						default: d.cfg = q.cfg;
					endcase
				end else if (q.cmd == CMD_RD_TEMP) begin
					read_temp = 1'b1;
				end
			end
			d.st = SER_IDLE;
			d.drive = 1'b0;
			d.bits = 5'h00;
		end else begin
			case (q.st)
				SER_IDLE: begin
					d.st = SER_CMD;
					d.bits = 5'h00;
					d.cmd = 8'h00;
				end
				SER_CMD: begin
					if (sclk_rise) begin
						d.cmd = cmd_next;
						d.bits = 5'(q.bits + 5'h01);
					end
					if (sclk_fall && q.bits == CMD_BITS) begin
						// valid command, start bit and direction bit pick the phase
						if (!valid_cmd(q.cmd) || !q.cmd[CMD_START_BIT]) begin
							d.st = SER_BAD;
						end else begin
							d.st = SER_DATA;
							d.drive = q.cmd[CMD_DIR_BIT];
							d.shift = {rd_word[14:0], 1'b0};
							d.sio_out = rd_word[15];
						end
					end
				end
				SER_DATA: begin
					if (sclk_rise) begin
						d.bits = (q.bits > FRAME_BITS) ? q.bits : 5'(q.bits + 5'h01);
						if (!q.cmd[CMD_DIR_BIT]) begin
							d.shift = {q.shift[14:0], sin};
						end
					end
					if (sclk_fall && q.cmd[CMD_DIR_BIT]) begin
						d.sio_out = q.shift[15];
						d.shift = {q.shift[14:0], 1'b0};
					end
				end
				default: begin
					d.st = SER_BAD;
					d.drive = 1'b0;
				end
			endcase
		end
		// ----------------------------------------
		// conversion engine
		// ----------------------------------------
		conv_done = 1'b0;
		if (access) begin
			d.conv_cnt = 32'h0;
		end else if (!q.cfg[CFG_SHDN_BIT]) begin
			if (q.conv_cnt >= CONV_CYCLES_P - 1) begin
				d.conv_cnt = 32'h0;
				conv_done = 1'b1;
			end else begin
				d.conv_cnt = q.conv_cnt + 32'h1;
			end
		end
		// ----------------------------------------
		// limit checks and fault queue
		// ----------------------------------------
		t = adc_temp & TEMP_MASK;
		hi_hy = 16'(q.high - q.hyst);
		lo_hy = 16'(q.low + q.hyst);
		cr_hy = 16'(q.crit - q.hyst);
		if (conv_done) begin
			d.hi_cnt = qstep(q.hi_cnt, gt(t, q.high), q.cfg[CFG_QUEUE_BIT]);
			d.lo_cnt = qstep(q.lo_cnt, gt(q.low, t), q.cfg[CFG_QUEUE_BIT]);
			d.ot_cnt = qstep(q.ot_cnt, gt(t, q.crit), q.cfg[CFG_QUEUE_BIT]);
			d.rhi_cnt = qstep(q.rhi_cnt, gt(hi_hy, t), q.cfg[CFG_QUEUE_BIT]);
			d.rlo_cnt = qstep(q.rlo_cnt, gt(t, lo_hy), q.cfg[CFG_QUEUE_BIT]);
			d.flags = {gt(t, q.crit), gt(t, q.high), gt(q.low, t)};
			d.temp = (t & 16'hfff8) | {13'h0000, d.flags};
			// overtemp comparator with hysteresis
			if (d.ot_cnt == QUEUE_DEPTH) begin
				d.ot_act = 1'b1;
			end else if (gt(cr_hy, t)) begin
				d.ot_act = 1'b0;
			end
			if (!q.cfg[CFG_INT_MODE_BIT]) begin
				if (d.hi_cnt == QUEUE_DEPTH || d.lo_cnt == QUEUE_DEPTH) begin
					d.alert_act = 1'b1;
				end else if (gt(hi_hy, t) && gt(t, lo_hy)) begin
					d.alert_act = 1'b0;
				end
			end else if (q.alert_act) begin
				// latched: only a clearing read releases it, side kept for rearm
				d.alert_act = 1'b1;
			end else if (q.int_hi) begin
				if (d.rhi_cnt == QUEUE_DEPTH) begin
					d.alert_act = 1'b1;
					d.int_hi = 1'b0;
				end
			end else if (q.int_lo) begin
				if (d.rlo_cnt == QUEUE_DEPTH) begin
					d.alert_act = 1'b1;
					d.int_lo = 1'b0;
				end
			end else if (d.hi_cnt == QUEUE_DEPTH || d.lo_cnt == QUEUE_DEPTH) begin
				d.alert_act = 1'b1;
				d.int_hi = d.hi_cnt == QUEUE_DEPTH;
				d.int_lo = d.hi_cnt != QUEUE_DEPTH;
				d.hi_cnt = 3'h0;
				d.lo_cnt = 3'h0;
			end
		end else begin
			d.temp = q.temp;
		end
		// clearing read rearms on the hysteresis side of the fault
		if (read_temp && q.cfg[CFG_INT_MODE_BIT] && q.alert_act) begin
			d.alert_act = 1'b0;
			d.rhi_cnt = 3'h0;
			d.rlo_cnt = 3'h0;
		end
		if (!q.cfg[CFG_INT_MODE_BIT]) begin
			d.int_hi = 1'b0;
			d.int_lo = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
			q.cs_s <= 2'b11;
			q.st <= SER_IDLE;
			q.cfg <= CFG_RST;
			q.hyst <= HYST_RST;
			q.crit <= CRIT_RST;
			q.low <= LOW_RST;
			q.high <= HIGH_RST;
			q.temp <= TEMP_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// pins
	// ----------------------------------------
	assign sio_out = q.sio_out;
	assign sio_oe = q.drive && !cs_hi;
	// open drain: drive low for a low level, release for high
	assign alert_out = 1'b0;
	assign alert_oe = q.alert_act ^ q.cfg[CFG_ALERT_POL_BIT];
	assign overtemp_output_out = 1'b0;
	assign overtemp_output_oe = q.ot_act ^ q.cfg[CFG_OT_POL_BIT];
	assign conv_strobe = conv_done;
	assign shutdown = q.cfg[CFG_SHDN_BIT];
endmodule : temp_alarm_core

// ==== shared/temp_alarm_pkg.sv ====
// constants and types for the temperature alarm serial core
package temp_alarm_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned CONV_PERIOD_MS = 500;
	localparam int unsigned CONV_CYCLES = (CLK_HZ / 1000) * CONV_PERIOD_MS;
	// ----------------------------------------
	// serial frame
	// ----------------------------------------
	localparam logic [4:0] CMD_BITS = 5'h08;
	localparam logic [4:0] FRAME_BITS = 5'h18;
	localparam logic [7:0] CMD_RD_TEMP = 8'hc1;
	localparam logic [7:0] CMD_RD_CFG = 8'hc3;
	localparam logic [7:0] CMD_RD_HYST = 8'hc5;
	localparam logic [7:0] CMD_RD_CRIT = 8'hc7;
	localparam logic [7:0] CMD_RD_LOW = 8'hc9;
	localparam logic [7:0] CMD_RD_HIGH = 8'hcb;
	localparam logic [7:0] CMD_WR_CFG = 8'h83;
	localparam logic [7:0] CMD_WR_HYST = 8'h85;
	localparam logic [7:0] CMD_WR_CRIT = 8'h87;
	localparam logic [7:0] CMD_WR_LOW = 8'h89;
	localparam logic [7:0] CMD_WR_HIGH = 8'h8b;
	localparam int unsigned CMD_START_BIT = 7;
	localparam int unsigned CMD_DIR_BIT = 6;
	// ----------------------------------------
	// configuration fields and reset values
	// ----------------------------------------
	localparam int unsigned CFG_QUEUE_BIT = 12;
	localparam int unsigned CFG_ALERT_POL_BIT = 11;
	localparam int unsigned CFG_OT_POL_BIT = 10;
	localparam int unsigned CFG_INT_MODE_BIT = 9;
	localparam int unsigned CFG_SHDN_BIT = 8;
	localparam logic [15:0] CFG_WR_MASK = 16'h1f00;
	localparam logic [15:0] LIMIT_MASK = 16'hff80;
	localparam logic [15:0] TEMP_MASK = 16'hfff8;
	localparam logic [15:0] CFG_RST = 16'h0000;
	localparam logic [15:0] HYST_RST = 16'h0100;
	localparam logic [15:0] CRIT_RST = 16'h2800;
	localparam logic [15:0] LOW_RST = 16'h0500;
	localparam logic [15:0] HIGH_RST = 16'h2000;
	localparam logic [15:0] TEMP_RST = 16'h0000;
	localparam logic [2:0] QUEUE_DEPTH = 3'h4;
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_CMD = 2'b01,
		SER_DATA = 2'b11,
		SER_BAD = 2'b10
	} ser_state_t;
	typedef struct packed {
		logic [1:0] cs_s;
		logic [1:0] sclk_s;
		logic [1:0] sio_s;
		logic sclk_prev;
		ser_state_t st;
		logic [4:0] bits;
		logic [7:0] cmd;
		logic [15:0] shift;
		logic drive;
		logic sio_out;
		logic [15:0] cfg;
		logic [15:0] hyst;
		logic [15:0] crit;
		logic [15:0] low;
		logic [15:0] high;
		logic [15:0] temp;
		logic [31:0] conv_cnt;
		logic [2:0] hi_cnt;
		logic [2:0] lo_cnt;
		logic [2:0] ot_cnt;
		logic [2:0] rhi_cnt;
		logic [2:0] rlo_cnt;
		logic alert_act;
		logic int_hi;
		logic int_lo;
		logic ot_act;
		logic [2:0] flags;
	} core_state_t;
endpackage : temp_alarm_pkg

// ==== sim/serial_master_model.sv ====
// serial bus master driving select, clock and data
`timescale 1ns/10ps
module serial_master_model (
	// clock
	input wire logic clk,
	// serial pins
	output logic cs_n,
	output logic sclk,
	output logic sio_in,
	input wire logic sio_out,
	input wire logic sio_oe
);
	logic m_oe;
	logic m_bit;
	// released line shows the inverse of the last bit
	assign sio_in = sio_oe ? sio_out : (m_oe ? m_bit : !m_bit);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		m_oe = 1'b0;
		m_bit = 1'b0;
	end
	task automatic frame(input logic [7:0] cmd, input logic [15:0] wd, input int n,
		output logic [15:0] rd);
		logic [23:0] w;
		w = {cmd, wd};
		rd = 16'h0000;
		@(negedge clk);
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			m_oe = (i < 8) || !cmd[6];
			m_bit = w[23 - (i % 24)];
			repeat (4) @(negedge clk);
			sclk = 1'b1;
			repeat (4) @(negedge clk);
			if (i >= 8)
				rd = {rd[14:0], sio_in};
			sclk = 1'b0;
		end
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		m_oe = 1'b0;
		repeat (8) @(negedge clk);
	endtask : frame
endmodule : serial_master_model

// ==== sim/temp_alarm_checker_assertions.sv ====
// concurrent checks on the temperature alarm core ports
`timescale 1ns/10ps
module temp_alarm_checker #(
	parameter int unsigned CONV_CYCLES_P = temp_alarm_pkg::CONV_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// serial pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sio_out,
	input wire logic sio_oe,
	// alarm pins and status
	input wire logic alert_out,
	input wire logic alert_oe,
	input wire logic overtemp_output_out,
	input wire logic overtemp_output_oe,
	input wire logic conv_strobe,
	input wire logic shutdown
);
	// ----------------------------------------
	// cycle counters
	// ----------------------------------------
	logic [3:0] cs_age_q;
	logic [3:0] conv_age_q;
	logic [31:0] gap_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_age_q <= 4'hf;
			conv_age_q <= 4'hf;
			gap_q <= 32'h00000000;
		end else begin
			cs_age_q <= !cs_n ? 4'h0 : cs_age_q + {3'h0, cs_age_q != 4'hf};
			conv_age_q <= conv_strobe ? 4'h0 : conv_age_q + {3'h0, conv_age_q != 4'hf};
			gap_q <= conv_strobe ? 32'h00000000 : gap_q + {31'h0, gap_q != 32'hffffffff};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	chk_idle_release: assert property (cs_n [*4] |-> !sio_oe)
		else $error("data line driven while deselected");
	chk_pins_open_drain: assert property (!alert_out && !overtemp_output_out)
		else $error("open drain pin driven high");
	chk_shdn_no_conv: assert property (shutdown && $past(shutdown) |-> !conv_strobe)
		else $error("conversion during shutdown");
	chk_conv_spacing: assert property (conv_strobe |-> gap_q >= 32'(CONV_CYCLES_P - 1))
		else $error("conversions too close");
	chk_drive_held: assert property (sio_oe && !cs_n |=> sio_oe)
		else $error("read drive dropped early");
	chk_bit_stable: assert property ((sio_oe && sclk) [*4] |-> $stable(sio_out))
		else $error("read bit changed in high phase");
	chk_ot_cause: assert property ($changed(overtemp_output_oe) |-> conv_age_q < 4'h6 || cs_age_q < 4'h8)
		else $error("overtemp changed without cause");
	chk_alert_cause: assert property ($changed(alert_oe) |-> conv_age_q < 4'h6 || cs_age_q < 4'h8)
		else $error("alert changed without cause");
	chk_shdn_cause: assert property ($changed(shutdown) |-> cs_n && cs_age_q < 4'h8)
		else $error("shutdown changed outside a write");
	cov_conv: cover property (conv_strobe);
	cov_read: cover property ($rose(sio_oe));
	cov_overtemp: cover property ($rose(overtemp_output_oe));
	cov_shdn: cover property ($rose(shutdown));
endmodule : temp_alarm_checker

bind temp_alarm_core temp_alarm_checker #(.CONV_CYCLES_P(CONV_CYCLES_P)) chk_i (.clk(clk),
	.arst_n(arst_n), .cs_n(cs_n), .sclk(sclk), .sio_out(sio_out), .sio_oe(sio_oe),
	.alert_out(alert_out), .alert_oe(alert_oe), .overtemp_output_out(overtemp_output_out),
	.overtemp_output_oe(overtemp_output_oe), .conv_strobe(conv_strobe), .shutdown(shutdown));

// ==== sim/temp_sensor_alarm_serial_tb_top.sv ====
// testbench for the temperature alarm core
`timescale 1ns/10ps
module temp_sensor_alarm_serial_tb_top;
	typedef struct packed {
		logic [7:0] cmd;
		logic [15:0] val;
		logic [4:0] n;
	} row_t;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic cs_n, sclk, sio_in, sio_out, sio_oe, conv_strobe, shutdown;
	logic alert_out, alert_oe, overtemp_output_out, overtemp_output_oe;
	logic [15:0] adc_temp = 16'h0c80;
	logic [15:0] rd;
	int mismatches = 0;
	int n_tests = 0;
	row_t rows [26] = '{'{8'hc3, 16'h0000, 5'h18}, '{8'hc5, 16'h0100, 5'h18},
		'{8'hc7, 16'h2800, 5'h18}, '{8'hc9, 16'h0500, 5'h18}, '{8'hcb, 16'h2000, 5'h18},
		'{8'h85, 16'h03ff, 5'h18}, '{8'hc5, 16'h0380, 5'h18}, '{8'h87, 16'h3abc, 5'h18},
		'{8'hc7, 16'h3a80, 5'h18}, '{8'h89, 16'h0fff, 5'h18}, '{8'hc9, 16'h0f80, 5'h18},
		'{8'h8b, 16'h1234, 5'h18}, '{8'hcb, 16'h1200, 5'h18}, '{8'h83, 16'hffff, 5'h18},
		'{8'hc3, 16'h1f00, 5'h18}, '{8'h83, 16'he0ff, 5'h18}, '{8'hc3, 16'h0000, 5'h18},
		'{8'h87, 16'h0000, 5'h17}, '{8'h87, 16'h0000, 5'h19}, '{8'h07, 16'h0000, 5'h18},
		'{8'h8d, 16'h0000, 5'h18}, '{8'hc7, 16'h3a80, 5'h18}, '{8'h85, 16'h01ff, 5'h18},
		'{8'h87, 16'h287f, 5'h18}, '{8'h89, 16'h057f, 5'h18}, '{8'h8b, 16'h207f, 5'h18}};
	always #20 clk = ~clk;
	temp_alarm_core #(.CONV_CYCLES_P(200)) dut (.clk(clk), .arst_n(arst_n), .cs_n(cs_n),
		.sclk(sclk), .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe),
		.alert_out(alert_out), .alert_oe(alert_oe), .overtemp_output_out(overtemp_output_out),
		.overtemp_output_oe(overtemp_output_oe), .adc_temp(adc_temp),
		.conv_strobe(conv_strobe), .shutdown(shutdown));
	serial_master_model master (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sio_in(sio_in),
		.sio_out(sio_out), .sio_oe(sio_oe));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic pins(input logic [1:0] e);
		check({14'h0, alert_oe, overtemp_output_oe}, {14'h0, e});
	endtask : pins
	task automatic do_reset();
		arst_n = 1'b0;
		adc_temp = 16'h0c80;
		repeat (12) @(negedge clk);
		arst_n = 1'b1;
		repeat (4) @(negedge clk);
	endtask : do_reset
	task automatic rdt();
		master.frame(8'hc1, 16'h0000, 24, rd);
	endtask : rdt
	task automatic conv(input logic [15:0] t, input int k);
		int w;
		adc_temp = t;
		repeat (k) begin
			for (w = 0; w < 500 && conv_strobe !== 1'b1; w++)
				@(negedge clk);
			if (w == 500) begin
				mismatches++;
				complete_run();
			end
			@(negedge clk);
		end
		repeat (4) @(negedge clk);
	endtask : conv
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		do_reset();
		pins(2'b00);
		foreach (rows[i]) begin
			master.frame(rows[i].cmd, rows[i].val, int'(rows[i].n), rd);
			if (rows[i].cmd[6])
				check(rd, rows[i].val);
		end
		$display("register table done");
		do_reset();
		conv(16'h2900, 1);
		pins(2'b11);
		rdt();
		check(rd, 16'h2906);
		pins(2'b11);
		conv(16'h2780, 1);
		pins(2'b11);
		conv(16'h1f40, 1);
		pins(2'b10);
		conv(16'h1e00, 1);
		pins(2'b00);
		conv(16'h0400, 1);
		pins(2'b10);
		conv(16'h0580, 1);
		pins(2'b10);
		conv(16'h0700, 1);
		pins(2'b00);
		master.frame(8'h83, 16'h0c00, 24, rd);
		pins(2'b11);
		conv(16'h2900, 1);
		pins(2'b00);
		$display("comparator mode done");
		do_reset();
		master.frame(8'h83, 16'h0200, 24, rd);
		conv(16'h2100, 1);
		pins(2'b10);
		conv(16'h1f40, 1);
		pins(2'b10);
		conv(16'h2100, 1);
		rdt();
		pins(2'b00);
		conv(16'h2100, 1);
		pins(2'b00);
		conv(16'h1e00, 1);
		pins(2'b10);
		rdt();
		pins(2'b00);
		conv(16'h0400, 1);
		pins(2'b10);
		rdt();
		pins(2'b00);
		conv(16'h0580, 1);
		pins(2'b00);
		conv(16'h0700, 1);
		pins(2'b10);
		$display("interrupt mode done");
		do_reset();
		master.frame(8'h83, 16'h1200, 24, rd);
		conv(16'h2900, 3);
		pins(2'b00);
		conv(16'h2900, 1);
		pins(2'b11);
		rdt();
		pins(2'b01);
		conv(16'h1e00, 3);
		check({15'h0, alert_oe}, 16'h0000);
		conv(16'h1e00, 1);
		check({15'h0, alert_oe}, 16'h0001);
		$display("fault queue done");
		do_reset();
		conv(16'h0c80, 1);
		master.frame(8'h83, 16'h0100, 24, rd);
		check({15'h0, shutdown}, 16'h0001);
		adc_temp = 16'h2900;
		repeat (500) @(negedge clk);
		pins(2'b00);
		rdt();
		check(rd, 16'h0c80);
		$display("shutdown done");
		complete_run();
	end
endmodule : temp_sensor_alarm_serial_tb_top
